// >>> logic/csi_pkg.sv
// Constants, carriers and helpers shared by the convolutional interleaver
`default_nettype none

package csi_pkg;

    // ********************************************************************
    // Sizes and timing
    // ********************************************************************
    localparam int SYM_W   = 8;
    localparam int NUM_BR  = 4;
    localparam int BR_W    = 2;
    localparam int NUM_CFG = 2;
    localparam int CFG_W   = 1;
    localparam int SLOT_W  = 4;
    // Sample edge to output edge: write stage, then read stage
    localparam int LATENCY = 2;

    localparam logic [BR_W-1:0]   BRANCH0   = 2'h0;
    localparam logic [BR_W-1:0]   BR_LAST   = 2'h3;
    localparam logic [CFG_W-1:0]  CFG_RESET = 1'h0;
    localparam logic [SLOT_W-1:0] SLOT0     = 4'h0;

    // Branch length = offset + branch * step, per configuration
    localparam logic [NUM_CFG-1:0][SLOT_W-1:0] LEN_OFFSET = {4'h1, 4'h0};
    localparam logic [NUM_CFG-1:0][SLOT_W-1:0] LEN_STEP   = {4'h2, 4'h1};

    // ********************************************************************
    // Memory layout
    // ********************************************************************
    function automatic logic [SLOT_W-1:0] branch_len(
        input logic [CFG_W-1:0] cfg,
        input logic [BR_W-1:0]  br);
        logic [7:0] prod;
        prod = 8'(br) * 8'(LEN_STEP[cfg]);
        return SLOT_W'(prod) + LEN_OFFSET[cfg];
    endfunction

    // A branch of length L keeps L+1 slots so a zero-length branch works
    function automatic logic [SLOT_W-1:0] branch_slots(
        input logic [CFG_W-1:0] cfg,
        input logic [BR_W-1:0]  br);
        return branch_len(cfg, br) + SLOT_W'(1);
    endfunction

    function automatic int max_slots(input int br);
        int m;
        m = 0;
        for (int c = 0; c < NUM_CFG; c++) begin
            if (int'(branch_slots(CFG_W'(c), BR_W'(br))) > m) begin
                m = int'(branch_slots(CFG_W'(c), BR_W'(br)));
            end
        end
        return m;
    endfunction

    function automatic int branch_base(input int br);
        int s;
        s = 0;
        for (int j = 0; j < br; j++) begin
            s = s + max_slots(j);
        end
        return s;
    endfunction

    localparam int MEM_DEPTH = branch_base(NUM_BR);
    localparam int ADDR_W    = $clog2(MEM_DEPTH);

    // ********************************************************************
    // Carriers
    // ********************************************************************
    typedef struct packed {
        logic              strobe;
        logic [ADDR_W-1:0] loc;
        logic [SYM_W-1:0]  word;
    } csi_ram_wr_s;

    typedef struct packed {
        logic              read;
        logic              strobe;
        logic              first;
        logic              valid;
        logic [ADDR_W-1:0] loc;
    } csi_stage_s;

endpackage

`default_nettype wire

// >>> logic/csi_commutator.sv
// Commutator position, configuration register and sync-point tracking
`timescale 1ns/1ps
`default_nettype none

module csi_commutator (
    input  wire logic                        clock,
    input  wire logic                        nrst,
    input  wire logic                        ce,
    input  wire logic                        sync_clear,
    input  wire logic                        sample,
    input  wire logic                        first_valid,
    input  wire logic                        swap_req,
    input  wire logic [csi_pkg::CFG_W-1:0]   setup_choice,
    output logic      [csi_pkg::BR_W-1:0]    cur_branch,
    output logic      [csi_pkg::CFG_W-1:0]   cur_cfg,
    output logic                             swap_now,
    output logic                             sync_ready,
    output logic                             abort
);

    logic [csi_pkg::BR_W-1:0]  comm_r;
    logic [csi_pkg::CFG_W-1:0] cfg_r;

    assign swap_now   = first_valid & swap_req;
    assign cur_cfg    = swap_now ? setup_choice : cfg_r;
    assign cur_branch = first_valid ? csi_pkg::BRANCH0 : comm_r;
    // Combinational on purpose: the drop is visible the cycle after a pulse
    assign sync_ready = (comm_r == csi_pkg::BRANCH0);
    assign abort      = first_valid & ~sync_ready;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            comm_r <= csi_pkg::BRANCH0;
        end else if (ce) begin
            if (sync_clear) begin
                comm_r <= csi_pkg::BRANCH0;
            end else if (sample) begin
                if (cur_branch == csi_pkg::BR_LAST) begin
                    comm_r <= csi_pkg::BRANCH0;
                end else begin
                    comm_r <= cur_branch + csi_pkg::BR_W'(1);
                end
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cfg_r <= csi_pkg::CFG_RESET;
        end else if (ce) begin
            if (sync_clear) begin
                cfg_r <= csi_pkg::CFG_RESET;
            end else if (swap_now) begin
                cfg_r <= setup_choice;
            end
        end
    end

endmodule

`default_nettype wire

// >>> logic/csi_branch_ptr.sv
// Per-branch circular pointers and RAM location generation
`timescale 1ns/1ps
`default_nettype none

module csi_branch_ptr (
    input  wire logic                         clock,
    input  wire logic                         nrst,
    input  wire logic                         ce,
    input  wire logic                         sync_clear,
    input  wire logic                         step,
    input  wire logic                         restart,
    input  wire logic [csi_pkg::BR_W-1:0]     branch,
    input  wire logic [csi_pkg::CFG_W-1:0]    cfg,
    output logic      [csi_pkg::ADDR_W-1:0]   wr_loc,
    output logic      [csi_pkg::ADDR_W-1:0]   rd_loc
);

    logic [csi_pkg::SLOT_W-1:0] ptr_all [csi_pkg::NUM_BR];
    logic [csi_pkg::SLOT_W-1:0] cur_ptr;
    logic [csi_pkg::SLOT_W-1:0] rd_slot;
    logic [csi_pkg::ADDR_W-1:0] base;

    // A new configuration changes the slot counts, so pointers restart
    assign cur_ptr = restart ? csi_pkg::SLOT0 : ptr_all[branch];
    // Oldest slot is the one after the write slot: delay of L visits
    assign rd_slot = (cur_ptr + csi_pkg::SLOT_W'(1) ==
                      csi_pkg::branch_slots(cfg, branch)) ?
                     csi_pkg::SLOT0 : cur_ptr + csi_pkg::SLOT_W'(1);

    always_comb begin
        base = '0;
        for (int b = 0; b < csi_pkg::NUM_BR; b++) begin
            if (branch == csi_pkg::BR_W'(b)) begin
                base = csi_pkg::ADDR_W'(csi_pkg::branch_base(b));
            end
        end
    end

    assign wr_loc = base + csi_pkg::ADDR_W'(cur_ptr);
    assign rd_loc = base + csi_pkg::ADDR_W'(rd_slot);

    for (genvar g = 0; g < csi_pkg::NUM_BR; g++) begin : g_ptr
        logic [csi_pkg::SLOT_W-1:0] ptr_r;
        assign ptr_all[g] = ptr_r;
        always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
                ptr_r <= csi_pkg::SLOT0;
            end else if (ce) begin
                if (sync_clear) begin
                    ptr_r <= csi_pkg::SLOT0;
                end else if (step && branch == csi_pkg::BR_W'(g)) begin
                    ptr_r <= rd_slot;
                end else if (step && restart) begin
                    ptr_r <= csi_pkg::SLOT0;
                end
            end
        end
    end

endmodule

`default_nettype wire

// >>> logic/csi_conv_interleaver.sv
// Convolutional symbol interleaver control with external dual-port RAM port
`timescale 1ns/1ps
`default_nettype none

module csi_conv_interleaver (
    input  wire logic                        clock,
    input  wire logic                        nrst,
    input  wire logic                        clock_enable,
    input  wire logic                        sync_clear,
    input  wire logic [csi_pkg::SYM_W-1:0]   symbol_in,
    input  wire logic                        first_symbol_mark,
    input  wire logic                        new_input_strobe,
    input  wire logic                        setup_swap_flag,
    input  wire logic [csi_pkg::CFG_W-1:0]   setup_choice,
    output logic      [csi_pkg::SYM_W-1:0]   symbol_out,
    output logic                             first_symbol_out_flag,
    output logic                             output_strobe,
    output logic                             output_valid,
    output logic                             accept_ready,
    output logic                             sync_point_ready,
    output csi_pkg::csi_ram_wr_s             ram_write,
    output logic      [csi_pkg::ADDR_W-1:0]  ram_read_location,
    output logic                             ram_read_strobe,
    input  wire logic [csi_pkg::SYM_W-1:0]   ram_read_word
);

    // ********************************************************************
    // Input qualification
    // ********************************************************************
    logic                          run;
    logic                          sample;
    logic                          first_valid;
    logic [csi_pkg::BR_W-1:0]      cur_branch;
    logic [csi_pkg::CFG_W-1:0]     cur_cfg;
    logic                          swap_now;
    logic                          abort;
    logic [csi_pkg::ADDR_W-1:0]    wr_loc;
    logic [csi_pkg::ADDR_W-1:0]    rd_loc;

    assign run         = clock_enable & ~sync_clear;
    assign sample      = run & new_input_strobe;
    assign first_valid = sample & first_symbol_mark;

    // Always ready; a clear still blocks sampling through run
    assign accept_ready = 1'b1;

    csi_commutator u_comm (
        .clock        (clock),
        .nrst         (nrst),
        .ce           (clock_enable),
        .sync_clear   (sync_clear),
        .sample       (sample),
        .first_valid  (first_valid),
        .swap_req     (setup_swap_flag),
        .setup_choice (setup_choice),
        .cur_branch   (cur_branch),
        .cur_cfg      (cur_cfg),
        .swap_now     (swap_now),
        .sync_ready   (sync_point_ready),
        .abort        (abort)
    );

    csi_branch_ptr u_ptr (
        .clock      (clock),
        .nrst       (nrst),
        .ce         (clock_enable),
        .sync_clear (sync_clear),
        .step       (sample),
        .restart    (swap_now),
        .branch     (cur_branch),
        .cfg        (cur_cfg),
        .wr_loc     (wr_loc),
        .rd_loc     (rd_loc)
    );

    // ********************************************************************
    // Start and first-symbol tracking
    // ********************************************************************
    logic                          started_r;
    logic                          fpend_r;
    logic [csi_pkg::SLOT_W-1:0]    fcnt_r;
    logic                          live_r;
    logic                          eff_pend;
    logic [csi_pkg::SLOT_W-1:0]    eff_cnt;
    logic                          mark;
    logic                          tag_strobe;
    logic                          tag_valid;

    // The first symbol leaves branch 0 after L0 further branch-0 visits
    assign eff_pend = first_valid | fpend_r;
    assign eff_cnt  = first_valid ?
                      csi_pkg::branch_len(cur_cfg, csi_pkg::BRANCH0) : fcnt_r;
    assign mark     = sample & (cur_branch == csi_pkg::BRANCH0) &
                      eff_pend & (eff_cnt == csi_pkg::SLOT0);
    assign tag_strobe = sample & (started_r | first_valid);
    // Old contents flushed ahead of the first symbol are not valid
    assign tag_valid  = mark | (live_r & ~abort & ~swap_now);

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            started_r <= 1'b0;
        end else if (clock_enable) begin
            if (sync_clear) begin
                started_r <= 1'b0;
            end else if (first_valid) begin
                started_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            fpend_r <= 1'b0;
            fcnt_r  <= csi_pkg::SLOT0;
        end else if (clock_enable) begin
            if (sync_clear) begin
                fpend_r <= 1'b0;
                fcnt_r  <= csi_pkg::SLOT0;
            end else if (sample &&
                         cur_branch == csi_pkg::BRANCH0) begin
                fpend_r <= eff_pend & ~mark;
                fcnt_r  <= mark ? csi_pkg::SLOT0 :
                           eff_cnt - csi_pkg::SLOT_W'(1);
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            live_r <= 1'b0;
        end else if (clock_enable) begin
            if (sync_clear) begin
                live_r <= 1'b0;
            end else if (sample) begin
                live_r <= tag_valid;
            end
        end
    end

    // ********************************************************************
    // Pipeline: write stage, read stage, output stage
    // ********************************************************************
    csi_pkg::csi_stage_s s1_r;
    csi_pkg::csi_stage_s s2_r;
    logic                out_stb_r;
    logic                out_first_r;
    logic                out_valid_r;

    // Every stage holds while clock_enable is low, so a freeze stretches
    // the latency by one cycle per frozen cycle instead of dropping a symbol in flight.
    // Write port lags the sample by one edge, the read port by two
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ram_write <= '0;
        end else if (clock_enable) begin
            if (sync_clear) begin
                ram_write <= '0;
            end else begin
                ram_write.strobe <= sample;
                if (sample) begin
                    ram_write.loc  <= wr_loc;
                    ram_write.word <= symbol_in;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s1_r <= '0;
        end else if (clock_enable) begin
            if (sync_clear) begin
                s1_r <= '0;
            end else begin
                s1_r.read   <= sample;
                s1_r.strobe <= tag_strobe;
                s1_r.first  <= mark;
                s1_r.valid  <= tag_valid & tag_strobe;
                if (sample) begin
                    s1_r.loc <= rd_loc;
                end
            end
        end
    end

    // Read one edge after the write so a zero-length branch sees its data
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s2_r <= '0;
        end else if (clock_enable) begin
            if (sync_clear) begin
                s2_r <= '0;
            end else begin
                s2_r <= s1_r;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            out_stb_r   <= 1'b0;
            out_first_r <= 1'b0;
            out_valid_r <= 1'b0;
        end else if (clock_enable) begin
            if (sync_clear) begin
                out_stb_r   <= 1'b0;
                out_first_r <= 1'b0;
                out_valid_r <= 1'b0;
            end else begin
                out_stb_r   <= s2_r.strobe;
                out_first_r <= s2_r.first & s2_r.strobe;
                out_valid_r <= s2_r.valid;
            end
        end
    end

    assign ram_read_location     = s2_r.loc;
    assign ram_read_strobe       = s2_r.read;
    // Registered RAM output lines up with the output stage flags
    assign symbol_out            = ram_read_word;
    assign output_strobe         = out_stb_r;
    assign first_symbol_out_flag = out_first_r;
    assign output_valid          = out_valid_r;

    // ********************************************************************
    // Checks
    // ********************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    AST_FREEZE: assert property (!clock_enable |=>
        $stable(output_strobe) && $stable(ram_read_location) &&
        $stable(sync_point_ready) && $stable(ram_write))
        else $error("state moved while clock enable was low");

    AST_CLEAR: assert property (clock_enable && sync_clear |=>
        !output_strobe && !output_valid && sync_point_ready &&
        !ram_write.strobe && !ram_read_strobe)
        else $error("sync clear did not initialise the control");

    AST_LATENCY: assert property (tag_strobe ##1 run [*2]
        |=> output_strobe)
        else $error("output strobe not after the fixed latency");

    AST_ONE_OUT: assert property (ram_write.strobe && run
        |=> ram_read_strobe && ram_read_location == $past(s1_r.loc))
        else $error("sampled symbol produced no read");

    AST_NO_EARLY: assert property (output_strobe |-> started_r)
        else $error("output strobe before the first pulse");

    // A clear straight after the pulse may bring the arm home at once
    AST_READY_DROP: assert property (first_valid ##1
        !(clock_enable && sync_clear) |->
        !sync_point_ready ##1 !sync_point_ready)
        else $error("sync ready did not drop after a first pulse");

    AST_READY_BACK: assert property (!sync_point_ready && sample &&
        !first_valid && cur_branch == csi_pkg::BR_LAST |=> sync_point_ready)
        else $error("sync ready not back after a full rotation");

    AST_ABORT: assert property (abort && !mark |=> !live_r)
        else $error("abort kept flushed data marked valid");

    AST_BRANCH0: assert property (first_valid |->
        cur_branch == csi_pkg::BRANCH0 &&
        abort == !sync_point_ready)
        else $error("first pulse symbol not on branch 0");

    AST_SWAP: assert property (first_valid && setup_swap_flag
        ##1 !(first_valid && setup_swap_flag) |-> cur_cfg == $past(setup_choice))
        else $error("configuration choice not taken on swap");

    AST_KEEP: assert property (first_valid && !setup_swap_flag
        |-> cur_cfg == u_comm.cfg_r ##1 $stable(u_comm.cfg_r))
        else $error("configuration changed without swap flag");

    // An ordinary pulse on branch 0 keeps valid high, so the flag may
    // fall inside a run of valid symbols
    AST_FIRST_OUT: assert property (first_symbol_out_flag |->
        output_valid && output_strobe)
        else $error("first-out flag without valid output");

    AST_VALID_SUB: assert property (output_valid |-> output_strobe)
        else $error("output valid without output strobe");

    AST_WRITE: assert property (sample |=>
        ram_write.strobe && ram_write.word == $past(symbol_in) &&
        ram_write.loc == $past(wr_loc))
        else $error("sampled symbol not sent to the write port");

    AST_FIRST_PASS: assert property (mark ##1 run [*2]
        |=> first_symbol_out_flag)
        else $error("first-out flag missing for the first symbol");

    COV_ABORT: cover property (abort);
    COV_HELD:  cover property (first_valid [*2]);
    COV_SWAP:  cover property (swap_now ##[1:40] first_symbol_out_flag);
    COV_FIRST: cover property (first_symbol_out_flag ##1 output_valid);
    COV_FREEZE: cover property (output_strobe ##1 !clock_enable [*3]);

endmodule

`default_nettype wire

// >>> tb/csi_ram_model.sv
// Dual-port symbol RAM standing on the far side of the interleaver
`timescale 1ns/1ps
`default_nettype none

module csi_ram_model (
    input  wire logic                       clock,
    input  wire csi_pkg::csi_ram_wr_s       wr,
    input  wire logic [csi_pkg::ADDR_W-1:0] rd_loc,
    input  wire logic                       rd_en,
    output logic      [csi_pkg::SYM_W-1:0]  rd_word
);
    logic [csi_pkg::SYM_W-1:0] mem [csi_pkg::MEM_DEPTH];

    // Separate write and read ports; data leaves by the read port only
    always @(posedge clock) begin
        if (wr.strobe) begin
            mem[wr.loc] <= wr.word;
        end
        // Unread cycles scramble the port so stale data is never reused
        rd_word <= rd_en ? mem[rd_loc] : ~rd_word;
    end
endmodule

`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the convolutional interleaver control
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    typedef struct packed {
        logic v; logic f; logic k; logic [7:0] s;
    } csi_exp_s;
    logic clock = 0, nrst = 0, ce = 0, clr = 0, st = 0, mk = 0, sw = 0;
    logic [0:0] ch = 0;
    logic [7:0] din = 0, dout, rword;
    logic fo, os, ov, ar, spr, ren, ce_e = 0;
    csi_pkg::csi_ram_wr_s wr;
    logic [csi_pkg::ADDR_W-1:0] rloc;
    int br = 0, cfg = 0, err_count = 0, samples_checked = 0;
    bit em = 0, started = 0;
    logic [8:0] hist [4][$];
    logic [8:0] h;
    csi_exp_s q [$];
    csi_exp_s e, m;

    csi_conv_interleaver i_dut (.clock(clock), .nrst(nrst),
        .clock_enable(ce), .sync_clear(clr), .symbol_in(din),
        .first_symbol_mark(mk), .new_input_strobe(st),
        .setup_swap_flag(sw), .setup_choice(ch), .symbol_out(dout),
        .first_symbol_out_flag(fo), .output_strobe(os),
        .output_valid(ov), .accept_ready(ar), .sync_point_ready(spr),
        .ram_write(wr), .ram_read_location(rloc),
        .ram_read_strobe(ren), .ram_read_word(rword));
    csi_ram_model i_ram (.clock(clock), .wr(wr), .rd_loc(rloc),
        .rd_en(ren), .rd_word(rword));

    initial forever #4 clock = ~clock;

    task chk(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    task end_of_test;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ********************************************************************
    // Driver and reference: branch queues hold symbols with a first bit
    // ********************************************************************
    task cyc(input bit c, k, s, f, w, input logic [0:0] sel);
        @(negedge clock);
        chk(ar === 1'b1, "accept ready");
        if (started) chk(spr === (br == 0), "sync ready");
        ce = c; clr = k; st = s; mk = f; sw = w; ch = sel;
        din = 8'($urandom);
        if (c && k) begin
            br = 0; em = 0; started = 0; cfg = 0;
            foreach (hist[i]) hist[i].delete();
        end else if (c && s) begin
            if (f) begin
                // Swap or abort loses branch history
                if (w || br != 0) foreach (hist[i]) hist[i].delete();
                if (w || br != 0) em = 0;
                if (w) cfg = int'(sel);
                br = 0; started = 1;
            end
            if (started) begin
                hist[br].push_back({f, din});
                m = '0;
                if (hist[br].size() > (cfg ? 1 + 2 * br : br)) begin
                    h = hist[br].pop_front();
                    if (h[8]) em = 1;
                    m.k = 1; m.f = h[8]; m.s = h[7:0];
                end
                m.v = em;
                q.push_back(m);
            end
            br = (br + 1) % 4;
        end
    endtask

    task run(input int n);
        repeat (n) cyc($urandom % 8 != 0, 0, $urandom % 4 != 0, 0, 0, 0);
    endtask

    always @(posedge clock) ce_e <= ce;
    always @(negedge clock) if (ce_e && os === 1'b1) begin
        if (q.size() == 0) chk(0, "stray output strobe");
        else begin
            e = q.pop_front();
            chk(ov === e.v, "output valid");
            chk(fo === e.f, "first flag");
            if (e.k) chk(dout === e.s, "symbol");
        end
    end

    initial begin
        void'($urandom(32'h085b));
        repeat (3) @(negedge clock);
        nrst = 1;
        repeat (5) cyc(1, 0, 1, 0, 0, 0);
        cyc(1, 0, 1, 1, 1, 0);
        run(40);
        cyc(1, 0, 1, 0, 0, 0);
        cyc(1, 0, 1, 1, 0, 1);
        run(30);
        cyc(1, 0, 1, 1, 1, 1);
        run(80);
        repeat (5) cyc(1, 0, 0, 0, 0, 0);
        chk(q.size() == 0, "outputs lost");
        cyc(1, 1, 1, 0, 0, 0);
        cyc(0, 1, 1, 1, 1, 1);
        cyc(1, 1, 1, 1, 1, 1);
        repeat (3) cyc(1, 0, 0, 0, 0, 0);
        chk(spr === 1'b1, "clear to branch 0");
        cyc(1, 0, 1, 1, 1, 0);
        run(40);
        repeat (6) cyc(1, 0, 0, 0, 0, 0);
        chk(q.size() == 0, "outputs missing");
        end_of_test;
    end

    initial begin
        #20us;
        err_count++;
        end_of_test;
    end
endmodule

`default_nettype wire
